/* src/nfh_pkg.sv */
// Shared constants, register map and carrier types for the flash host
package nfh_pkg;
	// Clock and pin timing in their own units
	localparam int CLOCK_PERIOD_PS = 25000;
	localparam int T_SETUP_NS = 20;
	localparam int T_WRITE_PULSE_NS = 70;
	localparam int T_READ_ACCESS_NS = 120;
	localparam int T_HOLD_NS = 20;
	localparam int T_RESET_NS = 150;
	localparam int T_WAKE_NS = 1000;
	// Least times, rounded up to whole cycles
	localparam int SETUP_CYC = (T_SETUP_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int WRITE_CYC = (T_WRITE_PULSE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int READ_CYC = (T_READ_ACCESS_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int HOLD_CYC = (T_HOLD_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int RESET_CYC = (T_RESET_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int WAKE_CYC = (T_WAKE_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
	localparam int SYNC_CYC = 2;

	// Widths
	localparam int ADDR_W = 25;
	localparam int DATA_W = 16;
	localparam int REG_AW = 8;
	localparam int BLOCK_SHIFT = 17;

	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR_LO = 8'h04;
	localparam logic [7:0] REG_ADDR_HI = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0C;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_CONFIG = 8'h18;

	// Control fields
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_NO_WAIT_BIT = 9;
	localparam int CTRL_CLEAR_BIT = 10;
	// Status fields
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_FAIL_BIT = 3;
	localparam int ST_PIN_BIT = 4;
	localparam int ST_READ_OK_BIT = 5;
	localparam int ST_WRITE_OK_BIT = 6;
	// Configuration fields and reset value
	localparam int CFG_WORD_BIT = 0;
	localparam int CFG_PD_BIT = 1;
	localparam int CFG_CE_ON_LSB = 2;
	localparam int CFG_CE_OFF_LSB = 5;
	localparam logic [15:0] CFG_RESET = 16'h00E1;
	localparam logic [2:0] CE_IDLE_RESET = 3'h7;

	typedef enum logic [3:0] {
		OP_NONE, OP_READ, OP_READ_STATUS, OP_PROGRAM, OP_ERASE, OP_SUSPEND,
		OP_RESUME, OP_LOCK_SET, OP_LOCK_CLEAR, OP_PULSE_CFG, OP_CLEAR_STATUS
	} nfh_op_t;

	// One bus cycle asked of the cycle engine
	typedef struct packed {
		logic valid;
		logic write;
		logic [2:0] select;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} nfh_cyc_req_t;

	typedef struct packed {
		logic done;
		logic [DATA_W-1:0] rdata;
	} nfh_cyc_resp_t;

	// Flash pins driven by the cycle engine
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] data_out;
		logic data_oe;
		logic write_enable_n;
		logic output_enable_n;
		logic [2:0] select;
	} nfh_pins_t;
endpackage : nfh_pkg

/* src/nfh_bus_cycle.sv */
// Single asynchronous read or write cycle on the flash pins
`timescale 1ns/1ps
module nfh_bus_cycle
	import nfh_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_enable,
	input wire nfh_cyc_req_t req,
	input wire logic [2:0] ce_idle,
	input wire logic [DATA_W-1:0] data_in,
	output nfh_cyc_resp_t resp,
	output nfh_pins_t pins
);
	typedef enum logic [2:0] {
		PH_IDLE, PH_SETUP, PH_PULSE, PH_SYNC, PH_HOLD
	} nfh_phase_t;

	typedef struct packed {
		nfh_phase_t phase;
		logic write;
		logic [7:0] cnt;
		nfh_pins_t pins;
		logic [DATA_W-1:0] rdata;
		logic done;
		logic [DATA_W-1:0] d_meta;
		logic [DATA_W-1:0] d_sync;
	} nfh_eng_t;

	localparam nfh_eng_t ENG_RESET = '{
		phase: PH_IDLE,
		pins: '{write_enable_n: 1'b1, output_enable_n: 1'b1,
			select: CE_IDLE_RESET, default: '0},
		default: '0
	};

	nfh_eng_t cur;
	nfh_eng_t next;

	// Phase sequencing; every pin change comes from a flop
	always_comb
	begin
		next = cur;
		next.done = 1'b0;
		// Data bus is foreign to our clock: two flops before use
		next.d_meta = data_in;
		next.d_sync = cur.d_meta;
		case (cur.phase)
			PH_IDLE:
			begin
				next.pins.select = ce_idle;
				if (req.valid)
				begin
					next.write = req.write;
					next.pins.address = req.addr;
					next.pins.data_out = req.data;
					next.pins.data_oe = req.write;
					next.pins.select = req.select;
					next.cnt = 8'(SETUP_CYC - 1);
					next.phase = PH_SETUP;
				end
			end
			PH_SETUP:
				if (cur.cnt == 8'h00)
				begin
					next.pins.write_enable_n = ~cur.write;
					next.pins.output_enable_n = cur.write;
					next.cnt = cur.write ? 8'(WRITE_CYC - 1) : 8'(READ_CYC - 1);
					next.phase = PH_PULSE;
				end
				else
					next.cnt = cur.cnt - 8'h01;
			PH_PULSE:
				if (cur.cnt == 8'h00)
				begin
					if (cur.write)
					begin
						next.pins.write_enable_n = 1'b1;
						next.cnt = 8'(HOLD_CYC - 1);
						next.phase = PH_HOLD;
					end
					else
					begin
						// Hold output enable while the sample crosses in
						next.cnt = 8'(SYNC_CYC - 1);
						next.phase = PH_SYNC;
					end
				end
				else
					next.cnt = cur.cnt - 8'h01;
			PH_SYNC:
				if (cur.cnt == 8'h00)
				begin
					next.rdata = cur.d_sync;
					next.pins.output_enable_n = 1'b1;
					next.cnt = 8'(HOLD_CYC - 1);
					next.phase = PH_HOLD;
				end
				else
					next.cnt = cur.cnt - 8'h01;
			PH_HOLD:
				if (cur.cnt == 8'h00)
				begin
					next.pins.data_oe = 1'b0;
					next.pins.select = ce_idle;
					next.done = 1'b1;
					next.phase = PH_IDLE;
				end
				else
					next.cnt = cur.cnt - 8'h01;
			default:
				next = ENG_RESET;
		endcase
	end

	// State register
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cur <= ENG_RESET;
		else if (clock_enable)
			cur <= next;
	end

	assign pins = cur.pins;
	assign resp = '{done: cur.done, rdata: cur.rdata};
endmodule : nfh_bus_cycle

/* src/nfh_flash_host.sv */
// Host controller that drives the flash command front end through its pins
`timescale 1ns/1ps
// Overview of operation
// - Width select low: byte mode, A0 picks byte
// - Width select high: word mode, A0 ignored
// - Only command sequences start device automation
// - Wait reset and wake times after release
// - Set means one, cleared means zero
module nfh_flash_host
	import nfh_pkg::*;
#(
	parameter int TOP_ADDRESS_BIT = 23,
	parameter int READY_BIT = 7,
	parameter int POLL_LIMIT = 65535,
	parameter logic [7:0] CMD_READ_ARRAY = 8'h01,
	parameter logic [7:0] CMD_READ_STATUS = 8'h02,
	parameter logic [7:0] CMD_CLEAR_STATUS = 8'h03,
	parameter logic [7:0] CMD_PROGRAM = 8'h04,
	parameter logic [7:0] CMD_ERASE = 8'h05,
	parameter logic [7:0] CMD_CONFIRM = 8'h06,
	parameter logic [7:0] CMD_SUSPEND = 8'h07,
	parameter logic [7:0] CMD_LOCK_SETUP = 8'h08,
	parameter logic [7:0] CMD_LOCK_SET = 8'h09,
	parameter logic [7:0] CMD_LOCK_CLEAR = 8'h0A,
	parameter logic [7:0] CMD_CONFIG = 8'h0B
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_enable,
	input wire logic [REG_AW-1:0] reg_address,
	input wire logic [DATA_W-1:0] reg_write_data,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [DATA_W-1:0] reg_read_data,
	output logic [ADDR_W-1:0] flash_address,
	output logic [DATA_W-1:0] flash_data_out,
	output logic flash_data_oe,
	input wire logic [DATA_W-1:0] flash_data_in,
	output logic write_enable_n,
	output logic output_enable_n,
	output logic chip_enable_0,
	output logic chip_enable_1,
	output logic chip_enable_2,
	output logic width_select,
	output logic reset_powerdown_n,
	input wire logic sequencer_status_pin
);
	typedef enum logic [2:0] {
		S_IDLE, S_FIRST, S_SECOND, S_POLL, S_READ
	} nfh_fsm_t;

	typedef struct packed {
		nfh_fsm_t fsm;
		nfh_op_t op;
		logic no_wait;
		logic issued;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] result;
		logic [15:0] cfg;
		logic [DATA_W-1:0] bus_rdata;
		logic done;
		logic refused;
		logic fail;
		logic [15:0] poll_cnt;
		logic [15:0] wake_cnt;
		logic sts_meta;
		logic sts_sync;
		nfh_cyc_req_t req;
	} nfh_host_t;

	localparam nfh_host_t HOST_RESET = '{
		fsm: S_IDLE, op: OP_NONE, cfg: CFG_RESET, default: '0
	};
	// Address lines above the top used bit stay low
	localparam logic [ADDR_W-1:0] TOP_MASK =
		ADDR_W'((33'h1 << (TOP_ADDRESS_BIT + 1)) - 33'h1);
	localparam logic [ADDR_W-1:0] BLOCK_MASK =
		~ADDR_W'((33'h1 << BLOCK_SHIFT) - 33'h1);

	nfh_host_t cur;
	nfh_host_t next;
	nfh_cyc_resp_t resp;
	nfh_pins_t pins;

	logic [7:0] first_cmd;
	logic has_second;
	logic [DATA_W-1:0] second_word;
	logic block_op;
	logic wait_ready;
	logic read_after;
	logic word_mode;
	logic read_ok;
	logic write_ok;
	logic [ADDR_W-1:0] pin_addr;
	logic [2:0] ce_on;
	logic [15:0] status_view;

	// Command sequence for each host operation
	always_comb
	begin
		first_cmd = CMD_READ_ARRAY;
		has_second = 1'b0;
		second_word = cur.wdata;
		block_op = 1'b0;
		wait_ready = 1'b0;
		read_after = 1'b0;
		case (cur.op)
			OP_READ:
				read_after = 1'b1;
			OP_READ_STATUS:
			begin
				first_cmd = CMD_READ_STATUS;
				read_after = 1'b1;
			end
			OP_PROGRAM:
			begin
				first_cmd = CMD_PROGRAM;
				has_second = 1'b1;
				wait_ready = 1'b1;
			end
			OP_ERASE:
			begin
				first_cmd = CMD_ERASE;
				has_second = 1'b1;
				second_word = {8'h00, CMD_CONFIRM};
				block_op = 1'b1;
				wait_ready = 1'b1;
			end
			OP_SUSPEND:
			begin
				first_cmd = CMD_SUSPEND;
				wait_ready = 1'b1;
			end
			OP_RESUME:
				first_cmd = CMD_CONFIRM;
			OP_LOCK_SET:
			begin
				first_cmd = CMD_LOCK_SETUP;
				has_second = 1'b1;
				second_word = {8'h00, CMD_LOCK_SET};
				block_op = 1'b1;
				wait_ready = 1'b1;
			end
			OP_LOCK_CLEAR:
			begin
				first_cmd = CMD_LOCK_SETUP;
				has_second = 1'b1;
				second_word = {8'h00, CMD_LOCK_CLEAR};
				wait_ready = 1'b1;
			end
			OP_PULSE_CFG:
			begin
				// Mode code comes from the write data register
				first_cmd = CMD_CONFIG;
				has_second = 1'b1;
			end
			OP_CLEAR_STATUS:
				first_cmd = CMD_CLEAR_STATUS;
			default:
				first_cmd = CMD_READ_ARRAY;
		endcase
	end

	// Address as it goes to the pins
	always_comb
	begin
		word_mode = cur.cfg[CFG_WORD_BIT];
		pin_addr = cur.addr & TOP_MASK;
		if (block_op)
			pin_addr = pin_addr & BLOCK_MASK;
		if (word_mode)
			pin_addr[0] = 1'b0;
	end

	assign read_ok = cur.wake_cnt >= 16'(RESET_CYC);
	assign write_ok = cur.wake_cnt >= 16'(WAKE_CYC);
	assign ce_on = cur.cfg[CFG_CE_ON_LSB +: 3];
	assign status_view = {9'h000, write_ok, read_ok, cur.sts_sync, cur.fail,
		cur.refused, cur.done, cur.fsm != S_IDLE};

	// Register port, operation sequencing and status capture
	always_comb
	begin
		next = cur;
		next.req.valid = 1'b0;
		next.bus_rdata = '0;
		// Status pin is asynchronous to our clock
		next.sts_meta = sequencer_status_pin;
		next.sts_sync = cur.sts_meta;
		// Wake timer restarts every time the pin is released
		if (cur.cfg[CFG_PD_BIT])
			next.wake_cnt = '0;
		else if (!write_ok || !read_ok)
			next.wake_cnt = cur.wake_cnt + 16'h0001;

		if (reg_read)
			case (reg_address)
				REG_CTRL:
					next.bus_rdata = {6'h00, cur.no_wait, 5'h00, cur.op};
				REG_ADDR_LO:
					next.bus_rdata = cur.addr[15:0];
				REG_ADDR_HI:
					next.bus_rdata = {7'h00, cur.addr[ADDR_W-1:16]};
				REG_WDATA:
					next.bus_rdata = cur.wdata;
				REG_RDATA:
					next.bus_rdata = cur.result;
				REG_STATUS:
					next.bus_rdata = status_view;
				REG_CONFIG:
					next.bus_rdata = cur.cfg;
				default:
					next.bus_rdata = '0;
			endcase

		if (reg_write)
			case (reg_address)
				REG_CTRL:
				begin
					if (reg_write_data[CTRL_CLEAR_BIT])
					begin
						next.done = 1'b0;
						next.refused = 1'b0;
						next.fail = 1'b0;
					end
					if (reg_write_data[CTRL_START_BIT])
					begin
						if (cur.fsm != S_IDLE || !write_ok
							|| cur.cfg[CFG_PD_BIT]
							|| reg_write_data[CTRL_OP_LSB +: 4] == 4'h0
							|| reg_write_data[CTRL_OP_LSB +: 4] > 4'hA)
							next.refused = 1'b1;
						else
						begin
							next.op = nfh_op_t'(reg_write_data[CTRL_OP_LSB +: 4]);
							next.no_wait = reg_write_data[CTRL_NO_WAIT_BIT];
							next.issued = 1'b0;
							next.poll_cnt = '0;
							next.fsm = S_FIRST;
						end
					end
				end
				REG_ADDR_LO:
					next.addr[15:0] = reg_write_data;
				REG_ADDR_HI:
					next.addr[ADDR_W-1:16] = reg_write_data[ADDR_W-17:0];
				REG_WDATA:
					next.wdata = reg_write_data;
				REG_CONFIG:
					next.cfg = {8'h00, reg_write_data[7:0]};
				default:
					next.cfg = cur.cfg;
			endcase

		case (cur.fsm)
			S_IDLE:
				next.issued = 1'b0;
			S_FIRST:
				if (!cur.issued)
				begin
					next.issued = 1'b1;
					next.req = '{valid: 1'b1, write: 1'b1, select: ce_on,
						addr: pin_addr, data: {8'h00, first_cmd}};
				end
				else if (resp.done)
				begin
					next.issued = 1'b0;
					if (has_second)
						next.fsm = S_SECOND;
					else if (wait_ready && !cur.no_wait)
						next.fsm = S_POLL;
					else if (read_after)
						next.fsm = S_READ;
					else
					begin
						next.fsm = S_IDLE;
						next.done = 1'b1;
					end
				end
			S_SECOND:
				if (!cur.issued)
				begin
					next.issued = 1'b1;
					next.req = '{valid: 1'b1, write: 1'b1, select: ce_on,
						addr: pin_addr, data: second_word};
				end
				else if (resp.done)
				begin
					next.issued = 1'b0;
					next.fsm = (wait_ready && !cur.no_wait) ? S_POLL : S_IDLE;
					next.done = !(wait_ready && !cur.no_wait);
				end
			S_POLL:
				if (!cur.issued)
				begin
					next.issued = 1'b1;
					next.req = '{valid: 1'b1, write: 1'b0, select: ce_on,
						addr: pin_addr, data: '0};
				end
				else if (resp.done)
				begin
					next.issued = 1'b0;
					next.result = resp.rdata;
					if (resp.rdata[READY_BIT])
					begin
						next.fsm = S_IDLE;
						next.done = 1'b1;
					end
					else if (cur.poll_cnt == 16'(POLL_LIMIT))
					begin
						// Give up rather than hang the port forever
						next.fsm = S_IDLE;
						next.fail = 1'b1;
					end
					else
						next.poll_cnt = cur.poll_cnt + 16'h0001;
				end
			S_READ:
				if (!cur.issued)
				begin
					next.issued = 1'b1;
					next.req = '{valid: 1'b1, write: 1'b0, select: ce_on,
						addr: pin_addr, data: '0};
				end
				else if (resp.done)
				begin
					// byte mode keeps the low lane
					next.result = word_mode ? resp.rdata
						: {8'h00, resp.rdata[7:0]};
					next.issued = 1'b0;
					next.fsm = S_IDLE;
					next.done = 1'b1;
				end
			default:
				next.fsm = S_IDLE;
		endcase

		// Power-down aborts any sequence in flight
		if (cur.cfg[CFG_PD_BIT] && cur.fsm != S_IDLE)
		begin
			next.fsm = S_IDLE;
			next.fail = 1'b1;
			next.req.valid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cur <= HOST_RESET;
		else if (clock_enable)
			cur <= next;
	end

	nfh_bus_cycle u_cycle (
		.clock(clock),
		.rst_n(rst_n),
		.clock_enable(clock_enable),
		.req(cur.req),
		.ce_idle(cur.cfg[CFG_CE_OFF_LSB +: 3]),
		.data_in(flash_data_in),
		.resp(resp),
		.pins(pins)
	);

	// Pins and register port outputs, all from flops
	assign reg_read_data = cur.bus_rdata;
	assign flash_address = pins.address;
	assign flash_data_out = pins.data_out;
	assign flash_data_oe = pins.data_oe;
	assign write_enable_n = pins.write_enable_n;
	assign output_enable_n = pins.output_enable_n;
	assign chip_enable_0 = pins.select[0];
	assign chip_enable_1 = pins.select[1];
	assign chip_enable_2 = pins.select[2];
	assign width_select = cur.cfg[CFG_WORD_BIT];
	assign reset_powerdown_n = ~cur.cfg[CFG_PD_BIT];
endmodule : nfh_flash_host

/* verification/nfh_host_properties.sv */
// Pin and register port checks bound to the flash host
`timescale 1ns/1ps
module nfh_host_chk
	import nfh_pkg::*;
#(
	parameter int TOP_ADDRESS_BIT = 23
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic reg_read,
	input wire logic [DATA_W-1:0] reg_read_data,
	input wire logic [ADDR_W-1:0] flash_address,
	input wire logic [DATA_W-1:0] flash_data_out,
	input wire logic write_enable_n,
	input wire logic output_enable_n,
	input wire logic width_select,
	input wire logic reset_powerdown_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Write strobe low three cycles, read strobe seven
	sequence s_we;
		!write_enable_n [*3] ##1 write_enable_n;
	endsequence
	sequence s_oe;
		!output_enable_n [*7] ##1 output_enable_n;
	endsequence
	property p_rd_zero;
		!$past(reg_read) |-> reg_read_data == '0;
	endproperty
	property p_we;
		$fell(write_enable_n) |-> s_we;
	endproperty
	property p_oe;
		$fell(output_enable_n) |-> s_oe;
	endproperty
	property p_excl;
		!write_enable_n |-> output_enable_n;
	endproperty
	property p_hold;
		!write_enable_n |-> $stable(flash_address) && $stable(flash_data_out);
	endproperty
	property p_top;
		(flash_address >> (TOP_ADDRESS_BIT + 1)) == '0;
	endproperty
	property p_a0;
		width_select && !(write_enable_n && output_enable_n)
			|-> !flash_address[0];
	endproperty
	property p_pd;
		!reset_powerdown_n |-> write_enable_n;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("read data outside its cycle");
	a_we: assert property (p_we)
		else $error("write strobe length wrong");
	a_oe: assert property (p_oe)
		else $error("read strobe length wrong");
	a_excl: assert property (p_excl)
		else $error("both strobes low");
	a_hold: assert property (p_hold)
		else $error("address or data moved under write");
	a_top: assert property (p_top)
		else $error("address above top line");
	a_a0: assert property (p_a0)
		else $error("lowest line driven in word mode");
	a_pd: assert property (p_pd)
		else $error("write during power-down");
endmodule : nfh_host_chk

bind nfh_flash_host nfh_host_chk #(.TOP_ADDRESS_BIT(TOP_ADDRESS_BIT)) u_chk (
	.clock, .rst_n, .reg_read, .reg_read_data, .flash_address,
	.flash_data_out, .write_enable_n, .output_enable_n, .width_select,
	.reset_powerdown_n
);

/* verification/nfh_flash_model.sv */
// Behavioural flash device facing the host
`timescale 1ns/1ps
module nfh_flash_model
	import nfh_pkg::*;
#(
	parameter int BUSY_CYC = 60
)
(
	input wire logic clock,
	input wire logic [ADDR_W-1:0] address,
	input wire logic [DATA_W-1:0] data_in,
	input wire logic write_enable_n,
	input wire logic output_enable_n,
	input wire logic [2:0] chip_enables,
	input wire logic reset_powerdown_n,
	output logic [DATA_W-1:0] data_q,
	output logic sequencer_status_pin
);
	logic [7:0] pend = '0;
	logic [15:0] mem [int];
	logic [255:0] lock = '0;
	logic st_mode = '0, pulse_mode = '0, susp = '0, err = '0, pulse = '0;
	logic we_q = 1'h1, sts_q = 1'h1;
	logic [15:0] last = '0, q = '0;
	int busy = 0;
	int ks[$];
	wire ready = busy == 0 || susp;
	wire [7:0] c = data_in[7:0];
	// one lock and erase unit per 128 Kbyte block
	wire [7:0] blk = address[24:17];
	// enabled by the decoded enables all low and reset_powerdown_n high
	wire on = chip_enables == 3'h0 && reset_powerdown_n;
	// Released bus shows the inverse so a stale value never passes
	assign data_q = (on && !output_enable_n) ? q : ~last;
	// Pin comes from a flop so it never moves in the host's sampling step
	assign sequencer_status_pin = sts_q;
	// Device state follows the pins once a cycle
	always @(posedge clock)
	begin
		we_q <= write_enable_n;
		pulse <= pulse_mode && busy == 1 && !susp;
		if (on && !output_enable_n)
			last <= q;
		if (!reset_powerdown_n)
			{busy, pend, st_mode, err, susp} = '0;
		else
		begin
			if (busy > 0 && !susp)
				busy--;
			if (write_enable_n && !we_q && on)
				take();
		end
		q <= st_mode ? {8'h00, ready, 1'h0, err, 5'h00}
			: mem.exists(address) ? mem[address] : 16'hFFFF;
		// ready level, or a low pulse at completion
		sts_q <= pulse_mode ? !pulse
			: busy == 0 || susp || !reset_powerdown_n;
	end
	// commands; new work ignored while busy unless suspended
	task take;
		logic [7:0] p;
		p = pend;
		pend = 8'h00;
		st_mode = 1'h1;
		case (p)
			8'h04: commit(1'h0);
			8'h05: if (c == 8'h06) commit(1'h1);
			8'h08: lock = c == 8'h09 ? lock | 256'h1 << blk : '0;
			8'h0B: pulse_mode = c != 8'h00;
			default:
				case (c)
					8'h01: st_mode = 1'h0;
					8'h03: err = 1'h0;
					// suspend frees the array, confirm resumes
					8'h07: susp = busy != 0;
					8'h06: susp = 1'h0;
					8'h04, 8'h05, 8'h08, 8'h0B:
						pend = busy != 0 && !susp ? 8'h00 : c;
					default: ;
				endcase
		endcase
	endtask : take
	// one block only, locked blocks untouched
	task commit(input logic wipe);
		busy = BUSY_CYC;
		if (lock[blk])
			err = 1'h1;
		else if (!wipe)
			mem[address] = data_in;
		else
		begin
			ks.delete();
			foreach (mem[k])
				if (k >> 17 == blk) ks.push_back(k);
			foreach (ks[i])
				mem.delete(ks[i]);
		end
	endtask : commit
endmodule : nfh_flash_model

/* verification/testbench.sv */
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %0t: got %h want %h", $time, g, e); end end
module testbench
	import nfh_pkg::*;
;
	typedef struct {logic [7:0] a; logic [15:0] e;} nfh_row_t;
	nfh_row_t rows[5] = '{'{REG_CONFIG, 16'h00E1}, '{REG_STATUS, 16'h0070},
		'{8'h1C, 16'h0000}, '{REG_CTRL, 16'h0000}, '{REG_RDATA, 16'h0000}};
	logic [3:0] ops[5] = '{4'h2, 4'h7, 4'h8, 4'hA, 4'h9};
	logic clock = '0, rst_n = '0, reg_write = '0, reg_read = '0;
	logic [REG_AW-1:0] reg_address = '0;
	logic [DATA_W-1:0] reg_write_data = '0, rd, st;
	wire [DATA_W-1:0] reg_read_data, flash_data_out, dev_q, bus;
	wire [ADDR_W-1:0] flash_address;
	wire flash_data_oe, write_enable_n, output_enable_n, ce0, ce1, ce2;
	wire width_select, reset_powerdown_n, sts;
	int error_cnt = 0, cmp_count = 0;
	logic [40:0] wq[$];
	// Host owns the data lines while its driver is enabled, the device otherwise
	assign bus = flash_data_oe ? flash_data_out : dev_q;
	nfh_flash_host dut (.clock, .rst_n, .clock_enable(1'h1), .reg_address,
		.reg_write_data, .reg_write, .reg_read, .reg_read_data, .flash_address,
		.flash_data_out, .flash_data_oe, .flash_data_in(bus), .write_enable_n,
		.output_enable_n, .chip_enable_0(ce0), .chip_enable_1(ce1),
		.chip_enable_2(ce2), .width_select, .reset_powerdown_n,
		.sequencer_status_pin(sts));
	nfh_flash_model dev (.clock, .address(flash_address), .data_in(bus),
		.write_enable_n, .output_enable_n, .chip_enables({ce2, ce1, ce0}),
		.reset_powerdown_n, .data_q(dev_q), .sequencer_status_pin(sts));
	always #12.5 clock = !clock;
	// Log address and data of every write cycle
	always @(negedge write_enable_n)
		wq.push_back({flash_address, flash_data_out});
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_address <= a;
		reg_write_data <= d;
		reg_write <= 1'h1;
		@(posedge clock);
		reg_write <= 1'h0;
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		@(posedge clock);
		reg_address <= a;
		reg_read <= 1'h1;
		@(posedge clock);
		reg_read <= 1'h0;
		#1 rd = reg_read_data;
	endtask : rdr
	// Clear stale flags first so done belongs to this start
	task automatic run(input logic [3:0] op, input logic nw);
		wr(REG_CTRL, 16'h0400);
		wr(REG_CTRL, {6'h00, nw, 1'h1, 4'h0, op});
	endtask : run
	task automatic wait_done;
		repeat (300)
		begin
			rdr(REG_STATUS);
			if (rd[ST_DONE_BIT] === 1'h1)
				break;
		end
		st = rd;
	endtask : wait_done
	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	// Watchdog well beyond the expected run length
	initial
	begin
		#2000000;
		error_cnt++;
		close_out();
	end
	initial
	begin
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		repeat (50) @(posedge clock);
		foreach (rows[i])
		begin
			rdr(rows[i].a);
			`CHK(rd, rows[i].e)
		end
		// Erase from a mid-block address lands on the block base
		wr(REG_ADDR_LO, 16'hFFFF);
		wr(REG_ADDR_HI, 16'h0003);
		wq.delete();
		run(4'h4, 1'h0);
		wait_done;
		`CHK(st[3:0], 4'h2)
		`CHK(wq.size(), 2)
		`CHK(wq[0][40:16], 25'h0020000)
		`CHK({wq[0][7:0], wq[1][7:0]}, 16'h0506)
		rdr(REG_RDATA);
		`CHK(rd, 16'h0080)
		// Start while busy is refused; suspend then resume
		run(4'h4, 1'h1);
		wr(REG_CTRL, 16'h0103);
		rdr(REG_STATUS);
		`CHK(rd[ST_REFUSED_BIT], 1'h1)
		repeat (40) @(posedge clock);
		rdr(REG_STATUS);
		`CHK(rd[ST_PIN_BIT], 1'h0)
		run(4'h5, 1'h0);
		wait_done;
		rdr(REG_STATUS);
		`CHK(rd[ST_PIN_BIT], 1'h1)
		run(4'h6, 1'h0);
		wait_done;
		`CHK(st[3:0], 4'h2)
		// Byte mode keeps the lowest line, word mode drops it
		for (int m = 0; m < 2; m++)
		begin
			wr(REG_CONFIG, 16'h00E0 | 16'(m));
			wr(REG_ADDR_LO, 16'h0005);
			wr(REG_ADDR_HI, 16'h0000);
			wr(REG_WDATA, 16'h00A5);
			wq.delete();
			run(4'h3, 1'h0);
			wait_done;
			`CHK(width_select, m[0])
			`CHK(wq[1][40:16], 25'h5 - 25'(m))
			`CHK(wq[1][7:0], 8'hA5)
		end
		// Lines above the top bit stay low; erased cells read ones
		wr(REG_ADDR_HI, 16'h01FF);
		wq.delete();
		run(4'h1, 1'h0);
		wait_done;
		`CHK(wq[0][40:16], 25'h0FF0004)
		rdr(REG_RDATA);
		`CHK(rd, 16'hFFFF)
		foreach (ops[i])
		begin
			run(ops[i], 1'h0);
			wait_done;
			`CHK(st[3:0], 4'h2)
		end
		// Power-down refuses a start
		wr(REG_CONFIG, 16'h00E3);
		run(4'h2, 1'h0);
		rdr(REG_STATUS);
		`CHK({reset_powerdown_n, rd[ST_REFUSED_BIT]}, 2'h1)
		// Second reset, then a start inside the wake time
		@(posedge clock);
		rst_n <= 1'h0;
		repeat (2) @(posedge clock);
		`CHK({ce2, ce1, ce0, width_select, reset_powerdown_n}, 5'h1F)
		rst_n <= 1'h1;
		run(4'h2, 1'h0);
		rdr(REG_STATUS);
		`CHK(rd[ST_REFUSED_BIT], 1'h1)
		close_out();
	end
endmodule : testbench
